// ### ctrl_consts.svh
// Purpose: Constants for the call, conditional call, bit clear and invert unit.
// Assumes: 16-bit instruction words, 32-bit sum register.
// Notes:   Opcode patterns are compared against the first instruction word.
`ifndef CTRL_CONSTS_SVH
`define CTRL_CONSTS_SVH

`define OPC_CALL        8'h7A
`define OPC_CONDCALL_HI 6'h3A
`define OPC_INVERT      16'hBE00
`define OPC_CLR_HI      12'hBE4
`define SEL_INTM        4'h0
`define SEL_OVM         4'h2
`define SEL_SXM         4'h6
`define SEL_CNF         4'h4
`define SEL_TC          4'hA
`define SEL_CARRY       4'hE
`define SEL_XF          4'hC
`define ST0_OVM_BIT     11
`define ST0_INTM_BIT    9
`define ST1_TC_BIT      11
`define ST1_SXM_BIT     10
`define ST1_CARRY_BIT   9
`define ST1_CNF_BIT     12
`define ST1_XF_BIT      4
`define CALL_CYCLES     3'd4
`define SKIP_CYCLES     3'd2
`define SINGLE_CYCLES   3'd1
`define ST_RESET        16'h0000
`define SUM_RESET       32'h0000_0000

`endif

// ### ctrl_pkg.sv
// Purpose: Types shared by the execution unit and its environment.
// Assumes: Nothing beyond the constants header.
// Notes:   Holds types only.
package ctrl_pkg;
    typedef struct packed {
        logic [15:0] word0;
        logic [15:0] word1;
        logic [15:0] addr;
    } fetch_t;

    typedef struct packed {
        logic        push;
        logic [15:0] ret_addr;
        logic        jump;
        logic [15:0] target;
        logic        flush;
    } flow_t;

    typedef enum logic [1:0] {
        IDLE_S = 2'b00,
        BUSY_S = 2'b01
    } exec_state_t;
endpackage

// ### call_branch_flag_clear_exec.sv
// Purpose: Executes absolute call, conditional call, bit clear and invert.
// Assumes: Fetch presents two instruction words with a valid strobe.
// Notes:   External wait states arrive as a count on wait_i.
`timescale 1ns/1ns
`include "ctrl_consts.svh"

// Overview of operation
// - Invert replaces every sum register bit with its complement.
// - Invert leaves the carry flag as it was.
// - Conditional call is taken only when all selected conditions hold.
// - Failed conditional call pushes nothing and resumes after both words.
// - Taken discontinuity discards the two speculatively fetched words.
// - Absolute call loads its second word into the instruction pointer.
// - Clearing the test flag zeroes bit 11 of status word one only.
// - Invert from on-chip memory completes in one cycle plus wait states.
// - Bit clear from on-chip memory completes in one cycle plus waits.
// - Invert runs under repeat prefix, one cycle per repetition.
module call_branch_flag_clear_exec
    import ctrl_pkg::*;
#(
    parameter int WAIT_W = 4
) (
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Fetched instruction.
    input  wire logic              valid_i,
    input  wire ctrl_pkg::fetch_t  fetch_i,
    input  wire logic [WAIT_W-1:0] wait_i,
    input  wire logic [7:0]        rpt_count_i,
    input  wire logic              bio_low_i,
    // Results.
    output logic                   ready_o,
    output ctrl_pkg::flow_t        flow_o,
    output logic                   arp_we_o,
    output logic [2:0]             arp_o,
    output logic [31:0]            sum_o,
    output logic [15:0]            st0_o,
    output logic [15:0]            st1_o
);
    import ctrl_pkg::*;

    initial begin
        if (WAIT_W < 1 || WAIT_W > 8) $error("WAIT_W out of range");
    end

    exec_state_t state;
    logic [8:0]  busy_cnt;
    logic [31:0] sum;
    logic [15:0] st0;
    logic [15:0] st1;
    flow_t       flow;
    logic        arp_we;
    logic [2:0]  aux_pointer_select;
    logic [7:0]  rpt_left;

    // Decode of the first instruction word.
    wire [15:0] w0        = fetch_i.word0;
    wire        is_call   = w0[15:8] == `OPC_CALL;
    wire        is_cc     = w0[15:10] == `OPC_CONDCALL_HI;
    wire        is_inv    = w0 == `OPC_INVERT;
    wire        is_clr    = w0[15:4] == `OPC_CLR_HI && !w0[0];
    wire [3:0]  clr_sel   = w0[3:0];
    wire        go        = valid_i && ready_o;

    // Condition evaluation: zero, less-than, overflow, carry, test, pin.
    wire        acc_zero  = sum == 32'h0000_0000;
    wire        acc_neg   = sum[31];
    wire [1:0]  tp        = w0[9:8];
    wire        zl_ok     = (!w0[7] || (acc_zero == w0[3]))
                         && (!w0[6] || (acc_neg == w0[2]))
                         && (!w0[7] || !w0[6] || w0[3] || w0[2]
                             || (!acc_zero && !acc_neg));
    wire        v_ok      = !w0[5] || (st0[`ST0_OVM_BIT] == w0[1]);
    wire        c_ok      = !w0[4] || (st1[`ST1_CARRY_BIT] == w0[0]);
    wire        tp_ok     = (tp == 2'b00) ? bio_low_i :
                            (tp == 2'b01) ? st1[`ST1_TC_BIT] :
                            (tp == 2'b10) ? !st1[`ST1_TC_BIT] : 1'b1;
    wire        cc_true   = zl_ok && v_ok && c_ok && tp_ok;
    wire        taken     = is_call || (is_cc && cc_true);
    wire [15:0] after_two = 16'(fetch_i.addr + 16'h0002);

    // Cycles each instruction occupies, plus external wait states.
    wire [8:0]  waits     = 9'(wait_i);
    wire [8:0]  base_cyc  = taken ? 9'(`CALL_CYCLES) :
                            is_cc ? 9'(`SKIP_CYCLES) :
                            9'(`SINGLE_CYCLES);
    // Repetitions of the invert add one cycle each after the first pass.
    wire [8:0]  rpt_cyc   = is_inv ? 9'(rpt_count_i) : 9'd0;
    // Extra cycles beyond the taking cycle; zero means single cycle.
    wire [8:0]  next_busy = 9'(base_cyc + waits + rpt_cyc - 9'd1);

    // Control flow outputs for the fetch unit and stack.
    always_comb begin
        flow = '0;
        flow.push     = go && taken;
        flow.ret_addr = after_two;
        flow.jump     = go && (taken || is_cc);
        flow.target   = taken ? fetch_i.word1 : after_two;
        flow.flush    = go && taken;
    end

    assign ready_o  = state == IDLE_S;
    assign flow_o   = flow;
    assign arp_we_o = arp_we;
    assign arp_o    = aux_pointer_select;
    assign sum_o    = sum;
    assign st0_o    = st0;
    assign st1_o    = st1;

    // Busy counter enforcing instruction lengths and repeat counts.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state    <= IDLE_S;
            busy_cnt <= '0;
        end else if (state == IDLE_S) begin
            if (go && next_busy != 9'd0) begin
                state    <= BUSY_S;
                busy_cnt <= next_busy;
            end
        end else if (busy_cnt > 9'd1) begin
            busy_cnt <= busy_cnt - 9'd1;
        end else begin
            // Last busy cycle; ready rises for the following cycle.
            state    <= IDLE_S;
            busy_cnt <= '0;
        end
    end

    // Sum register inversion, once per repetition.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sum      <= `SUM_RESET;
            rpt_left <= 8'd0;
        end else if (go && is_inv) begin
            sum      <= ~sum;
            rpt_left <= rpt_count_i;
        end else if (state == BUSY_S && rpt_left != 8'd0) begin
            sum      <= ~sum;
            rpt_left <= rpt_left - 8'd1;
        end
    end

    // Status bit clearing; carry is never touched by inversion.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st0 <= `ST_RESET;
            st1 <= `ST_RESET;
        end else if (go && is_clr) begin
            unique case (clr_sel)
                `SEL_INTM:  st0[`ST0_INTM_BIT]  <= 1'b0;
                `SEL_OVM:   st0[`ST0_OVM_BIT]   <= 1'b0;
                `SEL_SXM:   st1[`ST1_SXM_BIT]   <= 1'b0;
                `SEL_CNF:   st1[`ST1_CNF_BIT]   <= 1'b0;
                `SEL_TC:    st1[`ST1_TC_BIT]    <= 1'b0;
                `SEL_CARRY: st1[`ST1_CARRY_BIT] <= 1'b0;
                `SEL_XF:    st1[`ST1_XF_BIT]    <= 1'b0;
                default: ;
            endcase
        end
    end

    // Auxiliary pointer update requested by the absolute call.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            arp_we <= 1'b0;
            aux_pointer_select    <= 3'd0;
        end else begin
            arp_we <= go && is_call && w0[7] && w0[3];
            aux_pointer_select    <= w0[2:0];
        end
    end

    a_invert_all: assert property (@(posedge clk_i) disable iff (rst_i)
        go && is_inv |=> sum == ~$past(sum))
        else $error("invert wrong");
    a_carry_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        go && is_inv |=> $stable(st1[`ST1_CARRY_BIT]))
        else $error("carry changed");
    a_cc_false: assert property (@(posedge clk_i) disable iff (rst_i)
        go && is_cc && !cc_true |-> !flow_o.push && flow_o.target == after_two)
        else $error("false call pushed");
    a_flush_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        flow_o.push |-> flow_o.flush)
        else $error("no flush");
    a_call_target: assert property (@(posedge clk_i) disable iff (rst_i)
        go && is_call |-> flow_o.jump && flow_o.target == fetch_i.word1)
        else $error("bad target");
    a_tc_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        go && is_clr && clr_sel == `SEL_TC |=> !st1[`ST1_TC_BIT]
        && st1[10:0] == $past(st1[10:0]))
        else $error("tc clear");
    a_single_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        go && (is_clr || (is_inv && rpt_count_i == 0)) && wait_i == 0
        |=> ready_o)
        else $error("not one cycle");
    a_call_push: assert property (@(posedge clk_i) disable iff (rst_i)
        go && taken |-> flow_o.push && flow_o.ret_addr == after_two)
        else $error("no push");
    c_call: cover property (@(posedge clk_i) go && is_call);
    c_cc_skip: cover property (@(posedge clk_i) go && is_cc && !cc_true);
    c_rpt_inv: cover property (@(posedge clk_i) go && is_inv && rpt_count_i != 0);
endmodule // call_branch_flag_clear_exec

// ### tb_top.sv
// Purpose: Self-checking bench for the call, bit clear and invert unit.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Status bits leave reset clear, so every clear must keep them so.
`timescale 1ns/1ns
`include "ctrl_consts.svh"
module tb_top;
    import ctrl_pkg::*;
    // Stimulus, observed outputs and bookkeeping.
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        valid_i = 1'b0;
    fetch_t      fetch_i = '0;
    logic [3:0]  wait_i = 4'h0;
    logic [7:0]  rpt_count_i = 8'h00;
    logic        bio_low_i = 1'b0;
    logic        ready_o;
    logic        arp_we_o;
    flow_t       flow_o;
    logic [2:0]  arp_o;
    logic [31:0] sum_o;
    logic [31:0] exp_sum;
    logic [15:0] st0_o;
    logic [15:0] st1_o;
    logic        taken;
    int          n_errors = 0;
    int          tests_run = 0;
    logic [3:0]  sels [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'hA, 4'hC, 4'hE};
    logic [7:0]  ccs [4] = '{8'h00, 8'h00, 8'h11, 8'h55};
    logic [1:0]  tps [4] = '{2'b11, 2'b01, 2'b11, 2'b11};

    // Free-running 100 MHz clock.
    always #5 clk_i = ~clk_i;

    // Unit under test.
    call_branch_flag_clear_exec #(.WAIT_W(4)) u_call_branch_flag_clear_exec (
        .clk_i(clk_i), .rst_i(rst_i), .valid_i(valid_i), .fetch_i(fetch_i),
        .wait_i(wait_i), .rpt_count_i(rpt_count_i), .bio_low_i(bio_low_i),
        .ready_o(ready_o), .flow_o(flow_o), .arp_we_o(arp_we_o),
        .arp_o(arp_o), .sum_o(sum_o), .st0_o(st0_o), .st1_o(st1_o));

    // Compares one value and reports a difference.
    task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // Prints the verdict and ends the run.
    task automatic summarize;
        if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // Call condition from the sum value; carry, overflow and flag are clear.
    function automatic logic cond_ok(logic [15:0] w, logic [31:0] s, logic b);
        logic [3:0] f;
        logic       t;
        f = {s == 32'h0, s[31], 2'b00};
        t = (w[9:8] == 2'b00) ? b : (w[9:8] != 2'b01);
        return t && (((f ^ w[3:0]) & w[7:4]) == 4'h0);
    endfunction

    // Builds a first instruction word of the given kind.
    function automatic logic [15:0] mk(int k);
        case (k)
            0: return {`OPC_CALL, 8'($urandom)};
            1: return {`OPC_CONDCALL_HI, 10'($urandom)};
            2: return {`OPC_CLR_HI, sels[$urandom_range(0, 6)]};
            default: return `OPC_INVERT;
        endcase
    endfunction

    // Issues one instruction and checks flow, timing and state.
    task automatic run(input logic [15:0] a0, input int k);
        logic [15:0] a1;
        logic [15:0] ad;
        int          tot;
        int          cyc;
        a1 = 16'($urandom);
        ad = 16'($urandom_range(0, 16'hFFF0));
        wait_i = 4'($urandom_range(0, 3));
        rpt_count_i = (k == 3) ? 8'($urandom_range(0, 3)) : 8'h00;
        bio_low_i = 1'($urandom);
        taken = (k == 0) || (k == 1 && cond_ok(a0, exp_sum, bio_low_i));
        tot = (taken ? 4 : (k == 1 ? 2 : 1)) + wait_i + rpt_count_i;
        fetch_i = '{a0, a1, ad};
        valid_i = 1'b1;
        #1;
        check("push", flow_o.push, taken);
        check("jump", flow_o.jump, taken || k == 1);
        if (k == 1 && !taken)
            check("skip_target", flow_o.target, ad + 16'h2);
        check("flush", flow_o.flush, taken);
        if (taken) begin
            check("ret_addr", flow_o.ret_addr, ad + 16'h2);
            check("target", flow_o.target, a1);
        end
        @(negedge clk_i);
        if (ready_o !== 1'b1) valid_i = 1'b0;
        check("arp_we", arp_we_o, k == 0 && a0[7] && a0[3]);
        for (cyc = 0; cyc < 40 && ready_o !== 1'b1; cyc++) @(negedge clk_i);
        if (cyc == 40) begin
            n_errors++;
            summarize();
        end
        check("cycles", cyc, tot - 1);
        if (k == 3 && !rpt_count_i[0]) exp_sum = ~exp_sum;
        check("sum", sum_o, exp_sum);
        check("st0", st0_o, `ST_RESET);
        check("st1", st1_o, `ST_RESET);
        check("arp", arp_o, a0[2:0]);
    endtask

    // Reset, corner cases, then random traffic.
    initial begin
        void'($urandom(32'h3F0ADFC1));
        exp_sum = `SUM_RESET;
        repeat (4) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        check("rst_ready", ready_o, 1'b1);
        check("rst_sum", sum_o, `SUM_RESET);
        foreach (sels[i]) run({`OPC_CLR_HI, sels[i]}, 2);
        run(`OPC_INVERT, 3);
        foreach (ccs[i]) run({`OPC_CONDCALL_HI, tps[i], ccs[i]}, 1);
        run({`OPC_CALL, 8'h88}, 0);
        repeat (200) begin
            int k;
            k = $urandom_range(0, 3);
            run(mk(k), k);
        end
        valid_i = 1'b0;
        summarize();
    end
endmodule // tb_top
